/* File: hdl/smic_ctrl.sv */
module smic_ctrl (
  // Clock and reset
  input wire logic i_sys_clk,
  input wire logic i_rst_n,
  // Peripheral control block access
  input wire logic [7:0] i_reg_addr,
  input wire logic i_reg_wr,
  input wire logic i_reg_rd,
  input wire logic [15:0] i_reg_wdata,
  output logic [15:0] o_reg_rdata,
  // Internal interrupt sources, levels on this clock
  input wire logic [2:0] i_timer_req,
  input wire logic [1:0] i_dma_req,
  // CPU interrupt acknowledge and vector
  input wire logic i_cpu_ack,
  output logic [7:0] o_vector,
  output logic o_vector_valid,
  output logic o_cpu_int,
  output logic o_slave_mode,
  // External pins
  input wire logic i_cpu_irq_input,
  input wire logic i_slave_select_input,
  output logic o_acknowledge_output,
  output logic o_slave_request_output
);
  import smic_pkg::*;

  // Register state
  logic [4:0] vbase_q;
  logic [4:0] mask_q;
  logic [4:0] mask_d;
  logic [4:0] pend_q;
  logic [4:0] pend_d;
  logic [4:0] isv_q;
  logic [4:0] isv_d;
  logic [4:0] req_prev_q;
  smic_lvl_t thr_q;
  smic_lvl_t prio_q [NSRC];
  logic slave_q;

  // Synchronised pins
  logic [1:0] pins_s;
  logic irq_pin_s;
  logic sel_pin_s;

  smic_sync2 #(
    .W(2)
  ) u_pin_sync (
    .i_sys_clk(i_sys_clk),
    .i_rst_n(i_rst_n),
    .i_async({i_slave_select_input, i_cpu_irq_input}),
    .o_sync(pins_s)
  );
  assign irq_pin_s = pins_s[0];
  assign sel_pin_s = pins_s[1];

  // Address decode
  wire wr_vec = i_reg_wr && (i_reg_addr == OFS_VECTOR);
  wire wr_eoi = i_reg_wr && (i_reg_addr == OFS_EOI);
  wire wr_mask = i_reg_wr && (i_reg_addr == OFS_MASK);
  wire wr_thr = i_reg_wr && (i_reg_addr == OFS_THRESH);
  wire wr_isv = i_reg_wr && (i_reg_addr == OFS_INSERV);
  wire wr_req = i_reg_wr && (i_reg_addr == OFS_REQUEST);
  wire wr_stat = i_reg_wr && (i_reg_addr == OFS_STATUS);
  wire wr_reloc = i_reg_wr && (i_reg_addr == OFS_RELOC);
  wire [4:0] ctl_hit = smic_ctl_hit(i_reg_addr);
  wire [4:0] wr_ctl = ctl_hit & {NSRC{i_reg_wr}};

  // Source request edges; sources are edge sensed after reset
  wire [4:0] src_lvl = {i_timer_req[2], i_timer_req[1], i_dma_req[1], i_dma_req[0], i_timer_req[0]};
  wire [4:0] src_edge = src_lvl & ~req_prev_q;

  // Priority resolution
  wire [NSRC*LVL_W-1:0] lvl_flat;
  wire [4:0] elig;
  wire is_any;
  wire [2:0] is_lvl;
  wire [2:0] is_idx;
  wire win_any;
  wire [2:0] win_lvl;
  wire [2:0] win_idx;
  wire [4:0] eoi_hit;
  wire [4:0] win_oh;

  for (genvar k = 0; k < NSRC; k++) begin : g_src
    assign lvl_flat[k*LVL_W +: LVL_W] = prio_q[k];
    assign elig[k] = pend_q[k] && !mask_q[k]
                     && (prio_q[k] <= thr_q)
                     && (!is_any || prio_q[k] <= is_lvl);
    assign eoi_hit[k] = wr_eoi && (prio_q[k] == i_reg_wdata[LVL_W-1:0]);
    assign win_oh[k] = win_idx == 3'(k);
  end

  smic_prio_pick u_isv_pick (
    .i_valid(isv_q),
    .i_level(lvl_flat),
    .o_any(is_any),
    .o_level(is_lvl),
    .o_index(is_idx)
  );

  smic_prio_pick u_req_pick (
    .i_valid(elig),
    .i_level(lvl_flat),
    .o_any(win_any),
    .o_level(win_lvl),
    .o_index(win_idx)
  );

  // Acknowledge is only claimed when the master has selected this slave
  wire ack_take = i_cpu_ack && slave_q && sel_pin_s && win_any;
  wire [4:0] ack_oh = win_oh & {NSRC{ack_take}};

  // Pending requests: source set beats acknowledge clear
  always_comb begin
    pend_d = pend_q & ~ack_oh;
    if (wr_req) begin
      pend_d = (pend_d & ~SRC_DMA) | (smic_from_flags(i_reg_wdata) & SRC_DMA);
    end
    if (wr_stat) begin
      pend_d[IDX_T0] = pend_d[IDX_T0] | i_reg_wdata[STAT_T0_BIT];
      pend_d[IDX_T1] = pend_d[IDX_T1] | i_reg_wdata[STAT_T1_BIT];
      pend_d[IDX_T2] = pend_d[IDX_T2] | i_reg_wdata[STAT_T2_BIT];
    end
    pend_d = pend_d | src_edge;
  end

  // In-service: acknowledge set beats end-of-interrupt clear
  always_comb begin
    isv_d = isv_q;
    if (wr_isv) begin
      isv_d = smic_from_flags(i_reg_wdata);
    end
    isv_d = (isv_d & ~eoi_hit) | ack_oh;
  end

  // One shared mask bit per source, reachable from two addresses
  always_comb begin
    mask_d = mask_q;
    if (wr_mask) begin
      mask_d = smic_from_flags(i_reg_wdata);
    end
    for (int k = 0; k < NSRC; k++) begin
      if (wr_ctl[k]) begin
        mask_d[k] = i_reg_wdata[CTL_MSK_BIT];
      end
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      pend_q <= '0;
      isv_q <= '0;
      mask_q <= MASK_ALL;
      req_prev_q <= '0;
    end else begin
      pend_q <= pend_d;
      isv_q <= isv_d;
      mask_q <= mask_d;
      req_prev_q <= src_lvl;
    end
  end

  for (genvar k = 0; k < NSRC; k++) begin : g_prio
    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
        prio_q[k] <= LEVEL_LOWEST;
      end else if (wr_ctl[k]) begin
        prio_q[k] <= i_reg_wdata[LVL_W-1:0];
      end
    end
  end

  // Configuration; vector base, priority threshold and slave mode bit
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      vbase_q <= VBASE_RESET;
      thr_q <= LEVEL_LOWEST;
      slave_q <= 1'b0;
    end else begin
      if (wr_vec) begin
        vbase_q <= i_reg_wdata[VBASE_LSB +: $bits(vbase_q)];
      end
      if (wr_thr) begin
        thr_q <= i_reg_wdata[LVL_W-1:0];
      end
      if (wr_reloc) begin
        slave_q <= i_reg_wdata[RELOC_SLAVE_BIT];
      end
    end
  end

  // Read mux; the end-of-interrupt address reads as zero
  wire [15:0] ctl_word [NSRC];
  logic [15:0] rd_word;
  for (genvar k = 0; k < NSRC; k++) begin : g_ctlrd
    assign ctl_word[k] = {12'h000, mask_q[k], prio_q[k]};
  end

  always_comb begin
    rd_word = 16'h0000;
    case (i_reg_addr)
      OFS_VECTOR: rd_word = {8'h00, vbase_q, 3'h0};
      OFS_MASK: rd_word = smic_to_flags(mask_q);
      OFS_THRESH: rd_word = {13'h0000, thr_q};
      OFS_INSERV: rd_word = smic_to_flags(isv_q);
      OFS_REQUEST: rd_word = smic_to_flags(pend_q);
      OFS_STATUS: rd_word = {13'h0000, pend_q[IDX_T2], pend_q[IDX_T1], pend_q[IDX_T0]};
      OFS_RELOC: rd_word = 16'(slave_q) << RELOC_SLAVE_BIT;
      OFS_CTL_T0: rd_word = ctl_word[IDX_T0];
      OFS_CTL_D0: rd_word = ctl_word[IDX_D0];
      OFS_CTL_D1: rd_word = ctl_word[IDX_D1];
      OFS_CTL_T1: rd_word = ctl_word[IDX_T1];
      OFS_CTL_T2: rd_word = ctl_word[IDX_T2];
      default: rd_word = 16'h0000;
    endcase
  end

  // Outputs, all registered
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_reg_rdata <= 16'h0000;
      o_vector <= 8'h00;
      o_vector_valid <= 1'b0;
      o_cpu_int <= 1'b0;
      o_slave_mode <= 1'b0;
      o_acknowledge_output <= 1'b0;
      o_slave_request_output <= 1'b0;
    end else begin
      if (i_reg_rd) begin
        o_reg_rdata <= rd_word;
      end
      o_vector_valid <= ack_take;
      if (ack_take) begin
        o_vector <= {vbase_q, win_lvl};
      end
      o_cpu_int <= slave_q && irq_pin_s;
      o_slave_mode <= slave_q;
      o_acknowledge_output <= slave_q && i_cpu_ack;
      o_slave_request_output <= slave_q && win_any && !ack_take;
    end
  end

  default clocking cb @(posedge i_sys_clk);
  endclocking
  default disable iff (!i_rst_n);

  // Plain signals for the sampled-value functions below
  wire [4:0] open_req = pend_q & ~mask_q;
  wire wdata_msk = i_reg_wdata[CTL_MSK_BIT];

  AST_VECTOR_FORM: assert property (
    ack_take |=> o_vector_valid && o_vector == {$past(vbase_q), $past(win_lvl)})
    else $error("vector not formed from base and level");
  AST_ACK_SETS_SERVICE: assert property (
    ack_take |=> isv_q[$past(win_idx)])
    else $error("in-service bit not set on acknowledge");
  AST_ACK_CLEARS_PENDING: assert property (
    ack_take && !src_edge[win_idx] && !wr_req && !wr_stat |=> !pend_q[$past(win_idx)])
    else $error("request bit not cleared on acknowledge");
  AST_EOI_CLEARS: assert property (
    wr_eoi && !ack_take && !wr_isv |=> (isv_q & $past(eoi_hit)) == 5'h00)
    else $error("end-of-interrupt left in-service bit set");
  AST_TIMER_REQ_READONLY: assert property (
    wr_req && !ack_take && src_edge == 5'h00 |=> (pend_q & SRC_TIMER) == ($past(pend_q) & SRC_TIMER))
    else $error("timer request bits changed by software write");
  AST_DMA_REQ_WRITE: assert property (
    wr_req |=> (pend_q & SRC_DMA) == ((smic_from_flags($past(i_reg_wdata)) | $past(src_edge)) & SRC_DMA))
    else $error("DMA request bits do not follow write");
  AST_MASK_SHARED: assert property (
    wr_ctl[IDX_D0] && !wr_mask |=> mask_q[IDX_D0] == $past(wdata_msk))
    else $error("control word mask not seen in mask register");
  AST_THRESHOLD: assert property (
    win_any |-> win_lvl <= thr_q)
    else $error("request below threshold forwarded");
  AST_NESTING: assert property (
    win_any && is_any |-> win_lvl <= is_lvl)
    else $error("lower priority nested over service");
  AST_REQ_OUT: assert property (
    slave_q && !ack_take && (elig != 5'h00) |=> o_slave_request_output)
    else $error("slave request not raised");
  AST_MASKED_SILENT: assert property (
    o_slave_request_output |-> $past(open_req) != 5'h00)
    else $error("masked source forwarded");

  COV_ACK: cover property (ack_take ##1 o_vector_valid);
  COV_NEST: cover property (is_any && ack_take);
  COV_EOI: cover property (wr_eoi && eoi_hit != 5'h00);
  COV_SET_CLEAR: cover property (ack_take && src_edge[win_idx]);
endmodule

/* File: hdl/smic_pkg.sv */
package smic_pkg;
  // Internal sources in index order: timer0, dma0, dma1, timer1, timer2
  localparam int unsigned NSRC = 5;
  localparam int unsigned LVL_W = 3;

  // Peripheral control block offsets
  localparam logic [7:0] OFS_VECTOR = 8'h20;
  localparam logic [7:0] OFS_EOI = 8'h22;
  localparam logic [7:0] OFS_MASK = 8'h28;
  localparam logic [7:0] OFS_THRESH = 8'h2A;
  localparam logic [7:0] OFS_INSERV = 8'h2C;
  localparam logic [7:0] OFS_REQUEST = 8'h2E;
  localparam logic [7:0] OFS_STATUS = 8'h30;
  localparam logic [7:0] OFS_CTL_T0 = 8'h32;
  localparam logic [7:0] OFS_CTL_D0 = 8'h34;
  localparam logic [7:0] OFS_CTL_D1 = 8'h36;
  localparam logic [7:0] OFS_CTL_T1 = 8'h38;
  localparam logic [7:0] OFS_CTL_T2 = 8'h3A;
  localparam logic [7:0] OFS_RELOC = 8'hFE;

  // Field layout
  localparam int unsigned CTL_MSK_BIT = 3;
  localparam int unsigned VBASE_LSB = 3;
  localparam int unsigned RELOC_SLAVE_BIT = 14;
  localparam int unsigned STAT_T0_BIT = 0;
  localparam int unsigned STAT_T1_BIT = 1;
  localparam int unsigned STAT_T2_BIT = 2;

  // Reset values
  localparam logic [2:0] LEVEL_LOWEST = 3'h7;
  localparam logic [4:0] MASK_ALL = 5'h1F;
  localparam logic [4:0] VBASE_RESET = 5'h00;

  // Source groups by index
  localparam logic [4:0] SRC_DMA = 5'h06;
  localparam logic [4:0] SRC_TIMER = 5'h19;
  localparam int unsigned IDX_T0 = 0;
  localparam int unsigned IDX_D0 = 1;
  localparam int unsigned IDX_D1 = 2;
  localparam int unsigned IDX_T1 = 3;
  localparam int unsigned IDX_T2 = 4;

  typedef logic [LVL_W-1:0] smic_lvl_t;

  // Source index to bit of the in-service, request and mask words
  function automatic logic [15:0] smic_to_flags(input logic [4:0] s);
    smic_to_flags = {10'h000, s[IDX_T2], s[IDX_T1], s[IDX_D1], s[IDX_D0], 1'b0, s[IDX_T0]};
  endfunction

  function automatic logic [4:0] smic_from_flags(input logic [15:0] f);
    smic_from_flags = {f[5], f[4], f[3], f[2], f[0]};
  endfunction

  // Control word offset decode, one hot by source index
  function automatic logic [4:0] smic_ctl_hit(input logic [7:0] a);
    smic_ctl_hit = {a == OFS_CTL_T2, a == OFS_CTL_T1, a == OFS_CTL_D1, a == OFS_CTL_D0, a == OFS_CTL_T0};
  endfunction
endpackage

/* File: hdl/smic_prio_pick.sv */
module smic_prio_pick (
  // Candidates and their levels, source index order
  input wire logic [smic_pkg::NSRC-1:0] i_valid,
  input wire logic [smic_pkg::NSRC*smic_pkg::LVL_W-1:0] i_level,
  // Winner: lowest level number, lowest index on a tie
  output logic o_any,
  output logic [smic_pkg::LVL_W-1:0] o_level,
  output logic [2:0] o_index
);
  import smic_pkg::*;

  always_comb begin
    o_any = 1'b0;
    o_level = LEVEL_LOWEST;
    o_index = 3'h0;
    for (int i = 0; i < NSRC; i++) begin
      if (i_valid[i] && (!o_any || i_level[i*LVL_W +: LVL_W] < o_level)) begin
        o_any = 1'b1;
        o_level = i_level[i*LVL_W +: LVL_W];
        o_index = 3'(i);
      end
    end
  end
endmodule

/* File: hdl/smic_sync2.sv */
module smic_sync2 #(
  parameter int unsigned W = 1
) (
  // Clock and reset
  input wire logic i_sys_clk,
  input wire logic i_rst_n,
  // Asynchronous level in, synchronised level out
  input wire logic [W-1:0] i_async,
  output logic [W-1:0] o_sync
);
  logic [W-1:0] meta_q;

  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      meta_q <= '0;
      o_sync <= '0;
    end else begin
      meta_q <= i_async;
      o_sync <= meta_q;
    end
  end
endmodule

/* File: tb/smic_master_model.sv */
module smic_master_model (
  // Clock and reset
  input wire logic i_sys_clk,
  input wire logic i_rst_n,
  // Slave side pins and vector
  input wire logic i_slave_request_output,
  input wire logic i_acknowledge_output,
  input wire logic [7:0] i_vector,
  input wire logic i_vector_valid,
  // Test control: withhold the slave select
  input wire logic i_refuse,
  // Outputs toward the slave
  output logic o_cpu_irq_input,
  output logic o_slave_select_input,
  output logic [9:0] o_table_addr
);
  timeunit 1ns;
  timeprecision 1ns;

  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_cpu_irq_input <= 1'b0;
      o_slave_select_input <= 1'b0;
      o_table_addr <= 10'h000;
    end else begin
      // Master forwards the slave request straight to the CPU
      o_cpu_irq_input <= i_slave_request_output;
      o_slave_select_input <= i_slave_request_output & ~i_refuse & ~i_acknowledge_output;
      if (i_vector_valid) begin
        o_table_addr <= {i_vector, 2'b00};
      end
    end
  end
endmodule

/* File: tb/testbench.sv */
module testbench import smic_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;

  logic i_sys_clk = 1'b0;
  logic i_rst_n = 1'b0;
  logic [7:0] i_reg_addr = 8'h00;
  logic i_reg_wr = 1'b0;
  logic i_reg_rd = 1'b0;
  logic [15:0] i_reg_wdata = 16'h0000;
  logic [15:0] o_reg_rdata;
  logic [2:0] i_timer_req = 3'h0;
  logic [1:0] i_dma_req = 2'h0;
  logic i_cpu_ack = 1'b0;
  logic [7:0] o_vector;
  logic o_vector_valid, o_cpu_int, o_slave_mode;
  logic cpu_irq, slave_sel, o_acknowledge_output, o_slave_request_output;
  logic refuse = 1'b0;
  logic [9:0] table_addr;
  int error_cnt = 0;
  int comparisons = 0;
  int cycles = 0;
  localparam logic [7:0] CTL [5] = '{OFS_CTL_T0, OFS_CTL_D0, OFS_CTL_D1, OFS_CTL_T1, OFS_CTL_T2};

  always #50 i_sys_clk = ~i_sys_clk;

  smic_ctrl smic_ctrl_i (
    .i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n), .i_reg_addr(i_reg_addr), .i_reg_wr(i_reg_wr),
    .i_reg_rd(i_reg_rd), .i_reg_wdata(i_reg_wdata), .o_reg_rdata(o_reg_rdata),
    .i_timer_req(i_timer_req), .i_dma_req(i_dma_req), .i_cpu_ack(i_cpu_ack), .o_vector(o_vector),
    .o_vector_valid(o_vector_valid), .o_cpu_int(o_cpu_int), .o_slave_mode(o_slave_mode),
    .i_cpu_irq_input(cpu_irq), .i_slave_select_input(slave_sel),
    .o_acknowledge_output(o_acknowledge_output), .o_slave_request_output(o_slave_request_output)
  );

  smic_master_model smic_master_model_i (
    .i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n), .i_slave_request_output(o_slave_request_output),
    .i_acknowledge_output(o_acknowledge_output), .i_vector(o_vector), .i_vector_valid(o_vector_valid),
    .i_refuse(refuse), .o_cpu_irq_input(cpu_irq), .o_slave_select_input(slave_sel),
    .o_table_addr(table_addr)
  );

  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(negedge i_sys_clk);
    i_reg_addr = a;
    i_reg_wdata = d;
    i_reg_wr = 1'b1;
    @(negedge i_sys_clk);
    i_reg_wr = 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [15:0] exp);
    @(negedge i_sys_clk);
    i_reg_addr = a;
    i_reg_rd = 1'b1;
    @(negedge i_sys_clk);
    i_reg_rd = 1'b0;
    check($sformatf("register %h", a), o_reg_rdata, exp);
  endtask

  // Pin synchronisers take a few edges; bounded so a dead path still ends
  task automatic wait_int();
    int n;
    n = 0;
    while (o_cpu_int !== 1'b1 && n < 20) begin
      @(negedge i_sys_clk);
      n++;
    end
    @(negedge i_sys_clk);
    check("cpu interrupt", {15'h0000, o_cpu_int}, 16'h0001);
  endtask

  task automatic settle(input logic exp_req);
    repeat (4) @(negedge i_sys_clk);
    check("slave request", {15'h0000, o_slave_request_output}, {15'h0000, exp_req});
  endtask

  task automatic ack(input logic v, input logic [7:0] vec);
    @(negedge i_sys_clk);
    i_cpu_ack = 1'b1;
    @(negedge i_sys_clk);
    i_cpu_ack = 1'b0;
    check("vector valid", {15'h0000, o_vector_valid}, {15'h0000, v});
    check("acknowledge pin", {15'h0000, o_acknowledge_output}, 16'h0001);
    if (v) begin
      check("vector", {8'h00, o_vector}, {8'h00, vec});
    end
  endtask

  always @(posedge i_sys_clk) begin
    cycles++;
    if (cycles == 5000) begin
      error_cnt++;
      tally_and_finish();
    end
  end

  initial begin
    repeat (4) @(negedge i_sys_clk);
    i_rst_n = 1'b1;
    check("slave mode", {15'h0000, o_slave_mode}, 16'h0000);
    rd(OFS_MASK, 16'h003D);
    rd(OFS_THRESH, 16'h0007);
    rd(OFS_INSERV, 16'h0000);
    rd(OFS_REQUEST, 16'h0000);
    rd(OFS_STATUS, 16'h0000);
    rd(OFS_EOI, 16'h0000);
    rd(8'h40, 16'h0000);
    for (int i = 0; i < 5; i++) begin
      rd(CTL[i], 16'h000F);
    end
    $display("test reset values done");
    wr(OFS_MASK, 16'h0000);
    rd(OFS_CTL_D1, 16'h0007);
    // Unique levels 1..5 in source order
    for (int i = 0; i < 5; i++) begin
      wr(CTL[i], 16'(i + 1));
    end
    wr(OFS_CTL_T2, 16'h000D);
    rd(OFS_MASK, 16'h0020);
    rd(OFS_CTL_T1, 16'h0004);
    wr(OFS_VECTOR, 16'h00A8);
    rd(OFS_VECTOR, 16'h00A8);
    wr(OFS_RELOC, 16'h4000);
    settle(1'b0);
    check("slave mode", {15'h0000, o_slave_mode}, 16'h0001);
    $display("test setup done");
    wr(OFS_REQUEST, 16'h0004);
    rd(OFS_REQUEST, 16'h0004);
    wait_int();
    ack(1'b1, 8'hAA);
    rd(OFS_INSERV, 16'h0004);
    check("table address", {6'h00, table_addr}, 16'h02A8);
    rd(OFS_REQUEST, 16'h0000);
    i_timer_req[1] = 1'b1;
    settle(1'b0);
    rd(OFS_REQUEST, 16'h0010);
    i_timer_req[0] = 1'b1;
    wait_int();
    ack(1'b1, 8'hA9);
    rd(OFS_INSERV, 16'h0005);
    $display("test nesting done");
    wr(OFS_EOI, 16'h0001);
    rd(OFS_INSERV, 16'h0004);
    wr(OFS_EOI, 16'h0002);
    rd(OFS_INSERV, 16'h0000);
    wr(OFS_THRESH, 16'h0003);
    settle(1'b0);
    wr(OFS_THRESH, 16'h0004);
    wait_int();
    ack(1'b1, 8'hAC);
    $display("test eoi and threshold done");
    wr(OFS_EOI, 16'h0004);
    wr(OFS_THRESH, 16'h0007);
    i_timer_req[2] = 1'b1;
    settle(1'b0);
    rd(OFS_STATUS, 16'h0004);
    wr(OFS_MASK, 16'h0000);
    wait_int();
    refuse = 1'b1;
    wr(OFS_REQUEST, 16'hFFFF);
    rd(OFS_REQUEST, 16'h002C);
    ack(1'b0, 8'h00);
    rd(OFS_REQUEST, 16'h002C);
    refuse = 1'b0;
    settle(1'b1);
    ack(1'b1, 8'hAA);
    rd(OFS_INSERV, 16'h0004);
    wr(OFS_REQUEST, 16'h0000);
    rd(OFS_REQUEST, 16'h0020);
    $display("test mask and refusal done");
    wr(OFS_INSERV, 16'h0010);
    rd(OFS_INSERV, 16'h0010);
    // Status write raises timer0; the DMA halt bit stays unimplemented
    wr(OFS_STATUS, 16'h8001);
    rd(OFS_STATUS, 16'h0005);
    rd(OFS_REQUEST, 16'h0021);
    $display("test in-service and status write done");
    tally_and_finish();
  end
endmodule
